// file: core/fws_poller.sv
// Flash status poller: drives a parallel flash and decodes its status bits.
//
// Behaviour
// - Suspend entry flips poll bit 0 to 1; host reads an erasing sector.
// - Host polls erase inside an erasing, unprotected sector.
// - Poll bit may flip before other bits are valid; host re-reads.
// - Programming 1 over 0 locks up with failure bit; host resets device.
// - Host checks window bit before and after each extra sector command.
`timescale 1ns/1ns
`include "fws_consts.svh"

module fws_poller #(
    parameter int ADDR_W  = 21,
    parameter int WIN_CYC = `FWS_WIN_CYC
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    output logic [ADDR_W-1:0]      flash_addr,
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n,
    input  wire logic [7:0]        dq_in,
    output logic [7:0]             dq_out,
    output logic                   dq_oe_n
);
    import fws_pkg::*;

    // Bus slave state.
    logic              ack_r, ack_nxt;
    logic [31:0]       rd_r, rd_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [7:0]        wdata_r, wdata_nxt;
    fws_op_t           op_r, op_nxt;
    logic              arm_r, arm_nxt;
    logic              start;

    // Sequencer state.
    fws_state_t        st_r, st_nxt;
    logic              iss_r, iss_nxt;
    logic              done_r, done_nxt;
    logic              fail_r, fail_nxt;
    logic              rej_r, rej_nxt;
    logic              susp_r, susp_nxt;
    logic              tog1_r, tog1_nxt;
    logic              tog2_r, tog2_nxt;
    logic [7:0]        first_r, first_nxt;
    logic [7:0]        last_r, last_nxt;
    logic [15:0]       win_r, win_nxt;
    logic [11:0]       wait_r, wait_nxt;

    // Cycle engine handshake.
    logic              cyc_req;
    logic              cyc_write;
    logic              cyc_done;
    logic [7:0]        cyc_rdata;
    fws_cy_state_t     cyc_state;
    logic              busy;
    logic              expect_bit;
    logic [31:0]       status;

    assign busy = (st_r != FWS_S_IDLE);

    // Program polls expect the written bit, erase and suspend expect a one.
    assign expect_bit = (op_r == FWS_OP_POLL_PROG) ?
                        wdata_r[`FWS_POLL_BIT] : 1'b1;

    assign status = {8'h00, last_r, first_r, tog1_r, tog2_r, susp_r,
                     (win_r != 16'h0000), rej_r, fail_r, done_r, busy};

    // Every access waits one cycle, so readdata comes from a flop and a
    // write lands on the single edge where waitrequest is low.
    always_comb begin
        ack_nxt   = ack_r;
        rd_nxt    = rd_r;
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        op_nxt    = op_r;
        arm_nxt   = arm_r;
        start     = 1'b0;
        if ((avs_read || avs_write) && !ack_r) begin
            ack_nxt = 1'b1;
            if (avs_address == `FWS_REG_CTRL) begin
                rd_nxt = {28'h0000000, arm_r, op_r};
            end else if (avs_address == `FWS_REG_ADDR) begin
                rd_nxt = 32'(addr_r);
            end else if (avs_address == `FWS_REG_WDATA) begin
                rd_nxt = {24'h000000, wdata_r};
            end else if (avs_address == `FWS_REG_STATUS) begin
                rd_nxt = status;
            end else if (avs_address == `FWS_REG_RDATA) begin
                rd_nxt = {24'h000000, last_r};
            end else begin
                rd_nxt = 32'h00000000;
            end
        end else begin
            ack_nxt = 1'b0;
        end
        // Writes while a sequence runs are dropped to keep it consistent.
        if (avs_write && ack_r && !busy) begin
            if (avs_address == `FWS_REG_CTRL) begin
                op_nxt  = fws_op_t'(
                    avs_writedata[`FWS_CTRL_OP_MSB:`FWS_CTRL_OP_LSB]);
                arm_nxt = avs_writedata[`FWS_CTRL_ARM_BIT];
                start   = 1'b1;
            end else if (avs_address == `FWS_REG_ADDR) begin
                addr_nxt = avs_writedata[ADDR_W-1:0];
            end else if (avs_address == `FWS_REG_WDATA) begin
                wdata_nxt = avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ack_r   <= 1'b0;
            rd_r    <= 32'h00000000;
            addr_r  <= '0;
            wdata_r <= 8'h00;
            op_r    <= FWS_OP_READ;
            arm_r   <= 1'b0;
        end else if (clk_en) begin
            ack_r   <= ack_nxt;
            rd_r    <= rd_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            op_r    <= op_nxt;
            arm_r   <= arm_nxt;
        end
    end

    assign avs_readdata    = rd_r;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

    // Sequencer. Each cycle state issues one flash access, then moves on when the
    // engine reports it finished; FWS_S_DP_RD and FWS_S_TG_RD2 repeat theirs until
    // the poll or toggle bit settles or the fail bit is set. Status is only meaningful once
    // software has written the full command, so polls start after it.
    always_comb begin
        st_nxt    = st_r;
        iss_nxt   = iss_r;
        done_nxt  = done_r;
        fail_nxt  = fail_r;
        rej_nxt   = rej_r;
        susp_nxt  = susp_r;
        tog1_nxt  = tog1_r;
        tog2_nxt  = tog2_r;
        first_nxt = first_r;
        last_nxt  = last_r;
        win_nxt   = (win_r != 16'h0000) ? win_r - 16'h0001 : win_r;
        wait_nxt  = (wait_r != 12'h000) ? wait_r - 12'h001 : wait_r;
        cyc_req   = 1'b0;
        cyc_write = (st_r == FWS_S_WR) || (st_r == FWS_S_SE_WR);
        if ((st_r != FWS_S_IDLE) && !iss_r && (wait_r == 12'h000)) begin
            cyc_req = (cyc_state == FWS_CY_IDLE);
            iss_nxt = cyc_req;
        end
        if (cyc_done) begin
            iss_nxt = 1'b0;
        end
        case (st_r)
            FWS_S_IDLE: begin
                if (start) begin
                    done_nxt = 1'b0;
                    fail_nxt = 1'b0;
                    rej_nxt  = 1'b0;
                    tog1_nxt = 1'b0;
                    tog2_nxt = 1'b0;
                    case (op_nxt)
                        FWS_OP_WRITE:      st_nxt = FWS_S_WR;
                        FWS_OP_POLL_PROG:  st_nxt = FWS_S_DP_RD;
                        FWS_OP_POLL_ERASE: st_nxt = FWS_S_DP_RD;
                        FWS_OP_TOGGLE:     st_nxt = FWS_S_TG_RD1;
                        FWS_OP_ADD_SECTOR: st_nxt = FWS_S_SE_PRE;
                        FWS_OP_SUSPEND:    st_nxt = FWS_S_WR;
                        default:           st_nxt = FWS_S_RD;
                    endcase
                end
            end
            FWS_S_WR: begin
                if (cyc_done) begin
                    if (op_r == FWS_OP_SUSPEND) begin
                        // Give the device its full suspend latency.
                        wait_nxt = 12'(`FWS_SUSP_CYC);
                        st_nxt   = FWS_S_FIN;
                    end else begin
                        if (arm_r) begin
                            win_nxt = 16'(WIN_CYC);
                        end
                        done_nxt = 1'b1;
                        st_nxt   = FWS_S_IDLE;
                    end
                end
            end
            FWS_S_RD: begin
                if (cyc_done) begin
                    last_nxt = cyc_rdata;
                    done_nxt = 1'b1;
                    st_nxt   = FWS_S_IDLE;
                end
            end
            FWS_S_DP_RD: begin
                if (cyc_done) begin
                    first_nxt = cyc_rdata;
                    if (cyc_rdata[`FWS_POLL_BIT] == expect_bit) begin
                        st_nxt = FWS_S_FIN;
                    end else if (cyc_rdata[`FWS_FAIL_BIT]) begin
                        st_nxt = FWS_S_DP_RE;
                    end
                end
            end
            FWS_S_DP_RE: begin
                // The poll bit may settle in the same read as the fail bit.
                if (cyc_done) begin
                    if (cyc_rdata[`FWS_POLL_BIT] == expect_bit) begin
                        st_nxt = FWS_S_FIN;
                    end else begin
                        last_nxt = cyc_rdata;
                        fail_nxt = 1'b1;
                        done_nxt = 1'b1;
                        st_nxt   = FWS_S_IDLE;
                    end
                end
            end
            FWS_S_FIN: begin
                // Final read gives a byte whose other bits are settled.
                if (cyc_done) begin
                    last_nxt = cyc_rdata;
                    if (op_r == FWS_OP_SUSPEND) begin
                        susp_nxt = cyc_rdata[`FWS_POLL_BIT];
                    end else if (op_r != FWS_OP_TOGGLE) begin
                        susp_nxt = 1'b0;
                    end
                    done_nxt = 1'b1;
                    st_nxt   = FWS_S_IDLE;
                end
            end
            FWS_S_TG_RD1: begin
                if (cyc_done) begin
                    first_nxt = cyc_rdata;
                    st_nxt    = FWS_S_TG_RD2;
                end
            end
            FWS_S_TG_RD2: begin
                // Each completed read moves the toggle bits once.
                if (cyc_done) begin
                    first_nxt = cyc_rdata;
                    tog1_nxt  = tog1_r | (cyc_rdata[`FWS_TOG1_BIT] !=
                                          first_r[`FWS_TOG1_BIT]);
                    tog2_nxt  = tog2_r | (cyc_rdata[`FWS_TOG2_BIT] !=
                                          first_r[`FWS_TOG2_BIT]);
                    if (cyc_rdata[`FWS_TOG1_BIT] == first_r[`FWS_TOG1_BIT]) begin
                        st_nxt = FWS_S_FIN;
                    end else if (cyc_rdata[`FWS_FAIL_BIT]) begin
                        st_nxt = FWS_S_TG_RE1;
                    end
                end
            end
            FWS_S_TG_RE1: begin
                if (cyc_done) begin
                    first_nxt = cyc_rdata;
                    st_nxt    = FWS_S_TG_RE2;
                end
            end
            FWS_S_TG_RE2: begin
                // Toggling may stop in the read that raised the fail bit.
                if (cyc_done) begin
                    if (cyc_rdata[`FWS_TOG1_BIT] == first_r[`FWS_TOG1_BIT]) begin
                        st_nxt = FWS_S_FIN;
                    end else begin
                        last_nxt = cyc_rdata;
                        fail_nxt = 1'b1;
                        done_nxt = 1'b1;
                        st_nxt   = FWS_S_IDLE;
                    end
                end
            end
            FWS_S_SE_PRE: begin
                if (cyc_done) begin
                    first_nxt = cyc_rdata;
                    st_nxt    = FWS_S_SE_WR;
                end
            end
            FWS_S_SE_WR: begin
                if (cyc_done) begin
                    win_nxt = 16'(WIN_CYC);
                    st_nxt  = FWS_S_SE_POST;
                end
            end
            FWS_S_SE_POST: begin
                // A closed window after the write means it may be lost.
                if (cyc_done) begin
                    last_nxt = cyc_rdata;
                    rej_nxt  = cyc_rdata[`FWS_WIN_BIT];
                    done_nxt = 1'b1;
                    st_nxt   = FWS_S_IDLE;
                end
            end
            default: st_nxt = FWS_S_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r    <= FWS_S_IDLE;
            iss_r   <= 1'b0;
            done_r  <= 1'b0;
            fail_r  <= 1'b0;
            rej_r   <= 1'b0;
            susp_r  <= 1'b0;
            tog1_r  <= 1'b0;
            tog2_r  <= 1'b0;
            first_r <= 8'h00;
            last_r  <= 8'h00;
            win_r   <= 16'h0000;
            wait_r  <= 12'h000;
        end else if (clk_en) begin
            st_r    <= st_nxt;
            iss_r   <= iss_nxt;
            done_r  <= done_nxt;
            fail_r  <= fail_nxt;
            rej_r   <= rej_nxt;
            susp_r  <= susp_nxt;
            tog1_r  <= tog1_nxt;
            tog2_r  <= tog2_nxt;
            first_r <= first_nxt;
            last_r  <= last_nxt;
            win_r   <= win_nxt;
            wait_r  <= wait_nxt;
        end
    end

    // Pin timing lives in the cycle engine.
    fws_cycle #(
        .ADDR_W (ADDR_W)
    ) u_cycle (
        .clock      (clock),
        .rst        (rst),
        .clk_en     (clk_en),
        .req        (cyc_req),
        .req_write  (cyc_write),
        .req_addr   (addr_r),
        .req_data   (wdata_r),
        .cy_state   (cyc_state),
        .done       (cyc_done),
        .rdata      (cyc_rdata),
        .flash_addr (flash_addr),
        .flash_ce_n (flash_ce_n),
        .flash_oe_n (flash_oe_n),
        .flash_we_n (flash_we_n),
        .dq_in      (dq_in),
        .dq_out     (dq_out),
        .dq_oe_n    (dq_oe_n)
    );

endmodule

// file: core/fws_consts.svh
// Constant definitions for the flash status poller: offsets, fields, timing.
`ifndef FWS_CONSTS_SVH
`define FWS_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave.
`define FWS_REG_CTRL       5'h00
`define FWS_REG_ADDR       5'h04
`define FWS_REG_WDATA      5'h08
`define FWS_REG_STATUS     5'h0c
`define FWS_REG_RDATA      5'h10

// Control register fields.
`define FWS_CTRL_OP_LSB    0
`define FWS_CTRL_OP_MSB    2
`define FWS_CTRL_ARM_BIT   3

// Status register fields.
`define FWS_ST_BUSY        0
`define FWS_ST_DONE        1
`define FWS_ST_FAIL        2
`define FWS_ST_REJECT      3
`define FWS_ST_WIN_OPEN    4
`define FWS_ST_SUSPENDED   5
`define FWS_ST_TOG2_CHG    6
`define FWS_ST_TOG1_CHG    7
`define FWS_ST_FIRST_LSB   8
`define FWS_ST_LAST_LSB    16

// Status bit positions on the flash data bus.
`define FWS_POLL_BIT       7
`define FWS_TOG1_BIT       6
`define FWS_FAIL_BIT       5
`define FWS_WIN_BIT        3
`define FWS_TOG2_BIT       2

// Timing: clock period and flash timing in their own units.
`define FWS_CLK_NS         8
`define FWS_T_ACC_NS       70
`define FWS_T_WP_NS        40
`define FWS_T_REC_NS       20
`define FWS_T_SUSP_US      15
`define FWS_T_WIN_US       50

// Least times and the suspend latency round up, the window time rounds down.
`define FWS_ACC_CYC  ((`FWS_T_ACC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_WP_CYC   ((`FWS_T_WP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_REC_CYC  ((`FWS_T_REC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_SUSP_CYC ((`FWS_T_SUSP_US * 1000 + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_WIN_CYC  ((`FWS_T_WIN_US * 1000) / `FWS_CLK_NS)

`endif

// file: core/fws_pkg.sv
// Types shared by the flash status poller modules.
package fws_pkg;

    // Operations that software starts through the control register.
    typedef enum logic [2:0] {
        FWS_OP_WRITE      = 3'h0,
        FWS_OP_READ       = 3'h1,
        FWS_OP_POLL_PROG  = 3'h2,
        FWS_OP_POLL_ERASE = 3'h3,
        FWS_OP_TOGGLE     = 3'h4,
        FWS_OP_ADD_SECTOR = 3'h5,
        FWS_OP_SUSPEND    = 3'h6
    } fws_op_t;

    // Flash bus cycle engine states.
    typedef enum logic [2:0] {
        FWS_CY_IDLE = 3'b001,
        FWS_CY_ACT  = 3'b010,
        FWS_CY_REC  = 3'b100
    } fws_cy_state_t;

    // Sequencer states.
    typedef enum logic [12:0] {
        FWS_S_IDLE    = 13'h0001,
        FWS_S_WR      = 13'h0002,
        FWS_S_RD      = 13'h0004,
        FWS_S_DP_RD   = 13'h0008,
        FWS_S_DP_RE   = 13'h0010,
        FWS_S_FIN     = 13'h0020,
        FWS_S_TG_RD1  = 13'h0040,
        FWS_S_TG_RD2  = 13'h0080,
        FWS_S_TG_RE1  = 13'h0100,
        FWS_S_TG_RE2  = 13'h0200,
        FWS_S_SE_PRE  = 13'h0400,
        FWS_S_SE_WR   = 13'h0800,
        FWS_S_SE_POST = 13'h1000
    } fws_state_t;

endpackage

// file: core/fws_cycle.sv
// Flash bus cycle engine: one read or write cycle per request.
`timescale 1ns/1ns
`include "fws_consts.svh"

module fws_cycle #(
    parameter int ADDR_W  = 21,
    parameter int ACC_CYC = `FWS_ACC_CYC,
    parameter int WP_CYC  = `FWS_WP_CYC,
    parameter int REC_CYC = `FWS_REC_CYC
) (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    input  wire logic                 req,
    input  wire logic                 req_write,
    input  wire logic [ADDR_W-1:0]    req_addr,
    input  wire logic [7:0]           req_data,
    output fws_pkg::fws_cy_state_t    cy_state,
    output logic                      done,
    output logic [7:0]                rdata,
    output logic [ADDR_W-1:0]         flash_addr,
    output logic                      flash_ce_n,
    output logic                      flash_oe_n,
    output logic                      flash_we_n,
    input  wire logic [7:0]           dq_in,
    output logic [7:0]                dq_out,
    output logic                      dq_oe_n
);
    import fws_pkg::*;

    fws_cy_state_t     st_r, st_nxt;
    logic [7:0]        cnt_r, cnt_nxt;
    logic              wr_r, wr_nxt;
    logic              done_r, done_nxt;
    logic [7:0]        rdata_r, rdata_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [7:0]        dout_r, dout_nxt;

    // Each cycle ends with strobes high for a recovery time, so every read
    // is a full chip-enable and output-enable toggle seen by the device.
    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        wr_nxt    = wr_r;
        done_nxt  = 1'b0;
        rdata_nxt = rdata_r;
        addr_nxt  = addr_r;
        dout_nxt  = dout_r;
        case (st_r)
            FWS_CY_IDLE: begin
                if (req) begin
                    st_nxt   = FWS_CY_ACT;
                    wr_nxt   = req_write;
                    addr_nxt = req_addr;
                    dout_nxt = req_data;
                    cnt_nxt  = req_write ? 8'(WP_CYC - 1) : 8'(ACC_CYC - 1);
                end
            end
            FWS_CY_ACT: begin
                if (cnt_r == 8'h00) begin
                    st_nxt  = FWS_CY_REC;
                    cnt_nxt = 8'(REC_CYC - 1);
                    if (!wr_r) begin
                        rdata_nxt = dq_in;
                    end
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            FWS_CY_REC: begin
                if (cnt_r == 8'h00) begin
                    st_nxt   = FWS_CY_IDLE;
                    done_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            default: st_nxt = FWS_CY_IDLE;
        endcase
    end

    // State registers; clk_en low freezes everything.
    always_ff @(posedge clock) begin
        if (rst) begin
            st_r    <= FWS_CY_IDLE;
            cnt_r   <= 8'h00;
            wr_r    <= 1'b0;
            done_r  <= 1'b0;
            rdata_r <= 8'h00;
            addr_r  <= '0;
            dout_r  <= 8'h00;
        end else if (clk_en) begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            wr_r    <= wr_nxt;
            done_r  <= done_nxt;
            rdata_r <= rdata_nxt;
            addr_r  <= addr_nxt;
            dout_r  <= dout_nxt;
        end
    end

    // Pin drive; data is only driven during the write pulse itself.
    assign cy_state   = st_r;
    assign done       = done_r & clk_en;
    assign rdata      = rdata_r;
    assign flash_addr = addr_r;
    assign flash_ce_n = (st_r != FWS_CY_ACT);
    assign flash_oe_n = !((st_r == FWS_CY_ACT) && !wr_r);
    assign flash_we_n = !((st_r == FWS_CY_ACT) && wr_r);
    assign dq_out     = dout_r;
    assign dq_oe_n    = !((st_r == FWS_CY_ACT) && wr_r);

endmodule

// file: tb/fws_flash_model.sv
// Behavioural flash device that reports status bits while busy.
`timescale 1ns/1ns
module fws_flash_model #(
    parameter logic [7:0] SUSP_CMD = 8'h5e // Arbitrary suspend code.
) (
    input  wire logic       ce_n,
    input  wire logic       oe_n,
    input  wire logic       we_n,
    input  wire logic [7:0] dq_w,
    input  wire logic       lock,
    output logic      [7:0] dq_r
);
    logic [7:0] last = 8'hff;
    logic [1:0] busy = 2'd0;
    logic       tog = 1'b0, ers = 1'b0;
    // A write latches the byte and starts a short algorithm; the suspend
    // code parks an erase. Chip enable rises in the same step as write
    // enable, so the edge alone marks the write and no race can drop it.
    always @(posedge we_n)
        if (dq_w == SUSP_CMD) busy = 2'd0;
        else {last, ers, busy} = {dq_w, dq_w == 8'h30, 2'd3};
    // Each finished read while busy advances the toggle; a locked program never ends.
    always @(posedge oe_n)
        if (busy != 0) {tog, busy} = {~tog, busy - {1'b0, !lock}};
    // A released bus shows the inverse so a late sample cannot pass by luck.
    // The first erase read still sees the window open.
    assign dq_r = (ce_n || oe_n) ? ~last :
                  (busy == 0) ? (ers ? 8'hff : last) :
                  ers ? {1'b0, tog, 2'h0, busy != 3, tog, 2'h0} :
                  {~last[7], tog, lock, 2'h0, 1'b1, 2'h0};
endmodule

// file: tb/fws_poller_monitor.sv
// Checker for the poller's flash strobe timing.
`timescale 1ns/1ns
module fws_poller_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic dq_oe_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Pulse shapes counted from the cycle after the first low cycle.
    sequence s_rd; (!flash_oe_n)[*8] ##1 flash_oe_n; endsequence
    sequence s_wr; (!flash_we_n)[*4] ##1 flash_we_n; endsequence
    AST_RD_LEN: assert property ($fell(flash_oe_n) |=> s_rd)
        else $error("read pulse length");
    AST_WR_LEN: assert property ($fell(flash_we_n) |=> s_wr)
        else $error("write pulse length");
    AST_REC: assert property ($rose(flash_ce_n) |-> flash_ce_n[*3])
        else $error("recovery too short");
    AST_RD_CE: assert property ($fell(flash_oe_n) |-> !flash_ce_n)
        else $error("read without chip enable");
    AST_WR_CE: assert property ($fell(flash_we_n) |-> $fell(flash_ce_n))
        else $error("write without chip enable");
    AST_CE_OE: assert property ($fell(flash_ce_n) |-> flash_oe_n ^ flash_we_n)
        else $error("chip enable without one strobe");
    AST_EXCL: assert property (!flash_oe_n |-> flash_we_n)
        else $error("read and write together");
    AST_DQ_DRV: assert property (dq_oe_n == flash_we_n)
        else $error("data driven outside write pulse");
    AST_END: assert property ($rose(flash_oe_n) |-> $rose(flash_ce_n))
        else $error("read end mismatch");
endmodule
bind fws_poller fws_poller_monitor u_mon (.clock(clock), .rst(rst),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .dq_oe_n(dq_oe_n));

// file: tb/testbench.sv
// Self-checking bench: Avalon tasks drive the poller against a flash model.
`timescale 1ns/1ns
`include "fws_consts.svh"
module testbench;
    import fws_pkg::*;
    logic        clock = 1'b0, rst, lock, avs_read, avs_write;
    logic        avs_waitrequest, flash_ce_n, flash_oe_n, flash_we_n;
    logic [4:0]  avs_address;
    logic [7:0]  dq_in, dq_out;
    logic [20:0] flash_addr;
    localparam logic [7:0] SUSP = 8'h5e; // Arbitrary suspend code.
    logic [31:0] avs_writedata, avs_readdata, st;
    int          bad_count = 0, compares = 0;
    fws_poller #(.WIN_CYC(64)) dut (.clock(clock), .rst(rst), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .flash_addr(flash_addr), .dq_oe_n(),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .dq_in(dq_in), .dq_out(dq_out));
    fws_flash_model #(.SUSP_CMD(SUSP)) fm (.ce_n(flash_ce_n), .oe_n(flash_oe_n),
        .we_n(flash_we_n), .dq_w(dq_out), .lock(lock), .dq_r(dq_in));
    // Free-running 125 MHz clock.
    initial forever #4 clock = ~clock;
    // Compare, bus cycle, operation and closing helpers.
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) bad_count++;
        if (s !== e) $display("wrong value %s exp %h seen %h", nm, e, s);
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        st = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        @(posedge clock);
    endtask
    task automatic run(input fws_op_t op, input logic [7:0] d);
        bus(1'b1, `FWS_REG_WDATA, {24'h0, d});
        bus(1'b1, `FWS_REG_CTRL, {29'h1, op});
        do bus(1'b0, `FWS_REG_STATUS, '0); while (st[2:1] == 2'b00);
        $display("test of op %0d ended", op);
    endtask
    task automatic report_and_stop();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Cut a hang short; the tests need only a few thousand cycles.
    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end
    // Reset for three cycles, then program, toggle, sector add, erase, suspend, array read and a locked program.
    initial begin
        {rst, lock, avs_read, avs_write} = 4'b1000;
        {avs_address, avs_writedata} = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, `FWS_REG_STATUS, '0);
        chk("reset status", st, '0);
        bus(1'b0, 5'h14, '0);
        chk("unmapped read", st, '0);
        run(FWS_OP_WRITE, 8'ha5);
        run(FWS_OP_POLL_PROG, 8'ha5);
        chk("program", {st[23:8], st[2:1]}, 18'h29695);
        run(FWS_OP_WRITE, 8'ha5);
        run(FWS_OP_TOGGLE, 8'ha5);
        chk("toggle", {st[23:16], st[7:6], st[2:1]}, 12'ha59);
        run(FWS_OP_WRITE, 8'h30);
        run(FWS_OP_ADD_SECTOR, 8'h30);
        chk("sector add", {st[19], st[3], st[2:1]}, 4'h1);
        bus(1'b1, `FWS_REG_ADDR, 32'h00012345);
        run(FWS_OP_POLL_ERASE, 8'h00);
        chk("erase", {st[23:8], st[2:1]}, 18'h3fffd);
        chk("poll address", {11'h000, flash_addr}, 32'h00012345);
        run(FWS_OP_WRITE, 8'h30);
        run(FWS_OP_SUSPEND, SUSP);
        chk("suspend", {st[5], st[23:16], st[2:1]}, 11'h7fd);
        run(FWS_OP_READ, 8'h00);
        bus(1'b0, `FWS_REG_RDATA, '0);
        chk("array read", st, 32'h000000ff);
        lock <= 1'b1;
        run(FWS_OP_WRITE, 8'h5a);
        run(FWS_OP_POLL_PROG, 8'h5a);
        chk("locked", {st[13], st[2]}, 2'b11);
        report_and_stop();
    end
endmodule
